// [include/lcd_ram_defines.vh]
// constants for the display ram write addressing block
`ifndef LCD_RAM_DEFINES_VH
`define LCD_RAM_DEFINES_VH

// ----------------------------------------------------------------
// register word index (byte address = index * 4)
// ----------------------------------------------------------------
`define REG_CTRL 6'h00
`define REG_PTR 6'h01
`define REG_DEVSEL 6'h02
`define REG_DATA 6'h03
`define REG_STATUS 6'h04
`define REG_RAMCOL 6'h05

// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define CTRL_MODE_LSB 0
`define PTR_W 6
`define SUB_W 3
`define STATUS_MATCH_BIT 3
`define STATUS_BUSY_BIT 4

// ----------------------------------------------------------------
// drive modes
// ----------------------------------------------------------------
`define MODE_STATIC 2'h0
`define MODE_MUX2 2'h1
`define MODE_MUX3 2'h2
`define MODE_MUX4 2'h3

// ----------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------
`define RST_MODE 2'h0
`define RST_PTR 6'h00
`define RST_SUB 3'h0
`define LAST_COL 6'h27
`define RAM_ROWS 4
`define RAM_COLS 40

`endif

// [hdl/sync2.v]
// two flip-flop synchroniser for a group of quasi-static levels
`timescale 1ns/1ps
module sync2 #(
  parameter WIDTH = 3
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // levels
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1;

  // the group may be sampled as one word only because the pins are
  // held steady while the device is being accessed
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule // sync2

// [hdl/lcd_ram_writer.v]
// display ram write addressing with ahb-lite register access
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`include "lcd_ram_defines.vh"

module lcd_ram_writer (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // hardware subaddress pins
  input wire hw_subaddr_pin_bit0,
  input wire hw_subaddr_pin_bit1,
  input wire hw_subaddr_pin_bit2,
  // display ram, column c row r at bit c*4+r
  output reg [`RAM_COLS*`RAM_ROWS-1:0] ramBits
);

  // ----------------------------------------------------------------
  // writer states
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_SHIFT = 2'b01;
  localparam ST_FINISH = 2'b10;

  reg [1:0] state;
  reg [1:0] mode;
  reg [`PTR_W-1:0] col;
  reg [1:0] row;
  reg [`SUB_W-1:0] subCnt;
  reg [7:0] shiftReg;
  reg [7:0] lastByte;
  reg [2:0] bitCnt;
  reg [`PTR_W-1:0] viewCol;
  reg phase;
  reg phaseWr;
  reg [5:0] phaseIdx;
  wire [`SUB_W-1:0] subPin;
  wire accept;
  wire match;
  wire rowLast;
  wire [7:0] bitIdx;
  wire dataWrite;
  wire regWrite;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // last row used per column; the column count per byte follows from it
  function [1:0] lastRow;
    input [1:0] m;
    begin
      case (m)
        `MODE_STATIC: lastRow = 2'h0;
        `MODE_MUX2: lastRow = 2'h1;
        `MODE_MUX3: lastRow = 2'h2;
        default: lastRow = 2'h3;
      endcase
    end
  endfunction

  function overflow;
    input [`PTR_W-1:0] c;
    begin
      overflow = (c == `LAST_COL);
    end
  endfunction

  function [`PTR_W-1:0] stepCol;
    input [`PTR_W-1:0] c;
    begin
      if (overflow(c)) begin
        stepCol = `RST_PTR;
      end else begin
        stepCol = c + 6'h01;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // subaddress pins
  // ----------------------------------------------------------------
  sync2 #(
    .WIDTH(`SUB_W)
  ) subSync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .asyncIn({hw_subaddr_pin_bit2, hw_subaddr_pin_bit1,
      hw_subaddr_pin_bit0}),
    .syncOut(subPin)
  );

  assign match = (subCnt == subPin);
  assign rowLast = (row == lastRow(mode));
  assign bitIdx = {col, row};
  assign accept = hsel && htrans[1] && hready;
  assign dataWrite = phase && phaseWr && (phaseIdx == `REG_DATA);
  assign regWrite = phase && phaseWr && hreadyout;

  // ----------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------
  function [31:0] readWord;
    input [5:0] idx;
    begin
      readWord = 32'h00000000;
      if (idx == `REG_CTRL) begin
        readWord[1:0] = mode;
      end else if (idx == `REG_PTR) begin
        readWord[`PTR_W-1:0] = col;
      end else if (idx == `REG_DEVSEL) begin
        readWord[`SUB_W-1:0] = subCnt;
      end else if (idx == `REG_DATA) begin
        readWord[7:0] = lastByte;
      end else if (idx == `REG_STATUS) begin
        readWord[`SUB_W-1:0] = subPin;
        readWord[`STATUS_MATCH_BIT] = match;
        readWord[`STATUS_BUSY_BIT] = (state != ST_IDLE);
      end else if (idx == `REG_RAMCOL) begin
        readWord[3:0] = ramBits[{viewCol, 2'b00} +: 4];
        readWord[13:8] = viewCol;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  // reads answer with no wait state; data writes hold hreadyout low
  // until every bit of the byte has been placed, so a second byte
  // can never overtake the first
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 1'b0;
      phaseWr <= 1'b0;
      phaseIdx <= 6'h00;
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (accept) begin
        phase <= 1'b1;
        phaseWr <= hwrite;
        phaseIdx <= haddr[7:2];
        hrdata <= hwrite ? 32'h00000000 : readWord(haddr[7:2]);
      end else if (phase && hreadyout) begin
        phase <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // pointer, subaddress counter and byte placement
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      hreadyout <= 1'b1;
      mode <= `RST_MODE;
      col <= `RST_PTR;
      row <= 2'h0;
      subCnt <= `RST_SUB;
      shiftReg <= 8'h00;
      lastByte <= 8'h00;
      bitCnt <= 3'h0;
      viewCol <= `RST_PTR;
      ramBits <= {(`RAM_COLS*`RAM_ROWS){1'b0}};
    end else begin
      if (accept && hwrite && haddr[7:2] == `REG_DATA) begin
        hreadyout <= 1'b0;
      end
      if (regWrite) begin
        if (phaseIdx == `REG_CTRL) begin
          mode <= hwdata[`CTRL_MODE_LSB +: 2];
        end else if (phaseIdx == `REG_PTR) begin
          // out-of-range loads fall back to column 0
          if (hwdata[`PTR_W-1:0] > `LAST_COL) begin
            col <= `RST_PTR;
          end else begin
            col <= hwdata[`PTR_W-1:0];
          end
          row <= 2'h0;
        end else if (phaseIdx == `REG_DEVSEL) begin
          subCnt <= hwdata[`SUB_W-1:0];
        end else if (phaseIdx == `REG_RAMCOL) begin
          if (hwdata[`PTR_W-1:0] > `LAST_COL) begin
            viewCol <= `RST_PTR;
          end else begin
            viewCol <= hwdata[`PTR_W-1:0];
          end
        end
      end
      case (state)
        ST_IDLE: begin
          if (dataWrite && !hreadyout) begin
            shiftReg <= hwdata[7:0];
            lastByte <= hwdata[7:0];
            bitCnt <= 3'h0;
            state <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          // one bit per cycle, msb first, down the rows of a column
          if (match) begin
            ramBits[bitIdx] <= shiftReg[7];
          end
          shiftReg <= {shiftReg[6:0], 1'b0};
          bitCnt <= bitCnt + 3'h1;
          if (rowLast) begin
            row <= 2'h0;
            col <= stepCol(col);
            if (overflow(col)) begin
              // counter moves between bits, so the rest of the byte
              // lands in the next device of the cascade
              subCnt <= subCnt + 3'h1;
            end
          end else begin
            row <= row + 2'h1;
          end
          if (bitCnt == 3'h7) begin
            state <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          // a partly used column still counts as one step
          if (row != 2'h0) begin
            row <= 2'h0;
            col <= stepCol(col);
            if (overflow(col)) begin
              subCnt <= subCnt + 3'h1;
            end
          end
          hreadyout <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // lcd_ram_writer

// [test/lcd_host_model.sv]
// host side model: ahb-lite master and subaddress pin driver
`timescale 1ns/1ps
module lcd_host_model (
  // clock
  input wire core_clk,
  // bus answer
  input wire hready,
  input wire [31:0] hrdata,
  // bus request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // subaddress pins
  output logic [2:0] pins
);
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata, pins} = '0;
    hsize = 3'h2;
  end
  // one single word transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [5:0] idx,
      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, idx, 2'h0};
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  // pins change only between transfers; wait out the synchroniser
  task automatic setPins(input logic [2:0] v);
    pins <= v;
    repeat (3) @(posedge core_clk);
  endtask
endmodule // lcd_host_model

// [test/lcd_ram_writer_props.sv]
// concurrent checks on the display ram writer ports
`timescale 1ns/1ps
`include "lcd_ram_defines.vh"
module lcd_ram_writer_props (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // pins and ram
  input wire hw_subaddr_pin_bit0,
  input wire hw_subaddr_pin_bit1,
  input wire hw_subaddr_pin_bit2,
  input wire [`RAM_COLS*`RAM_ROWS-1:0] ramBits
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire take = hsel & htrans[1] & hready;
  wire isData = haddr[7:2] == `REG_DATA;
  sequence placing;
    take && hwrite && isData;
  endsequence
  sequence stall10;
    !hreadyout [*8] ##1 !hreadyout [*2];
  endsequence
  stall_len_a: assert property (placing |=> stall10 ##1 hreadyout)
    else $error("data write stall length wrong");
  fast_read_a: assert property (take && !hwrite |=> hreadyout)
    else $error("read stalled");
  reg_write_a: assert property (take && hwrite && !isData |=> hreadyout)
    else $error("register write stalled");
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  ram_quiet_a: assert property ($changed(ramBits) |-> $past(!hreadyout))
    else $error("ram changed outside a data write");
  one_bit_a: assert property ($countones(ramBits ^ $past(ramBits)) <= 1)
    else $error("several ram bits changed at once");
  data_hold_a: assert property (!hreadyout && $past(!hreadyout) |-> $stable(hrdata))
    else $error("read data moved during stall");
  stall_cause_a: assert property ($fell(hreadyout) |-> $past(take && hwrite && isData))
    else $error("stall without data write");
endmodule // lcd_ram_writer_props
bind lcd_ram_writer lcd_ram_writer_props chk (.core_clk(core_clk),
  .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .hw_subaddr_pin_bit0(hw_subaddr_pin_bit0),
  .hw_subaddr_pin_bit1(hw_subaddr_pin_bit1),
  .hw_subaddr_pin_bit2(hw_subaddr_pin_bit2), .ramBits(ramBits));

// [test/lcd_ram_display_ram_write_addressing_tb.sv]
// self-checking bench for the display ram write addressing block
`timescale 1ns/1ps
`include "lcd_ram_defines.vh"
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module lcd_display_ram_write_addressing_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, mode;
  logic [2:0] hsize, pins, eSub, pinV;
  logic [159:0] ramBits, expRam;
  logic [5:0] ePtr;
  int errors = 0;
  int nChecks = 0;
  initial forever #25 core_clk = ~core_clk;
  lcd_host_model host (.core_clk(core_clk), .hready(hreadyout),
    .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .pins(pins));
  lcd_ram_writer dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .hw_subaddr_pin_bit0(pins[0]), .hw_subaddr_pin_bit1(pins[1]),
    .hw_subaddr_pin_bit2(pins[2]), .ramBits(ramBits));
  task automatic testDone();
    if (errors == 0 && nChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rdChk(input string nm, input logic [5:0] a,
      input logic [31:0] e);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h00000000, q);
    `CHK(nm, e, q)
  endtask
  // expected pointer step; past the last column the next device takes over
  task automatic nxt();
    if (ePtr == `LAST_COL) begin
      ePtr = 6'h00;
      eSub = eSub + 3'h1;
    end else begin
      ePtr = ePtr + 6'h01;
    end
  endtask
  // reference placement of one byte, then compare ram, pointer, counter
  task automatic byteChk(input logic [7:0] b);
    int row;
    row = 0;
    wr(`REG_DATA, {24'h000000, b});
    for (int i = 7; i >= 0; i--) begin
      if (eSub == pinV) expRam[ePtr*4+row] = b[i];
      row++;
      if (row == mode + 1) begin
        row = 0;
        nxt();
      end
    end
    if (row != 0) nxt();
    `CHK("ram", expRam, ramBits)
    rdChk("ptr", `REG_PTR, {26'h0000000, ePtr});
    rdChk("sub", `REG_DEVSEL, {29'h00000000, eSub});
  endtask
  initial begin
    // three edges in reset: the checker's first past values after release
    // are then reset values rather than the unknowns before the first edge
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    `CHK("rst ram", 160'h0, ramBits)
    {expRam, ePtr, eSub, pinV, mode} = '0;
    for (int m = 0; m < 4; m++) begin
      mode = 2'(m);
      wr(`REG_CTRL, 32'(m));
      wr(`REG_PTR, 32'h00000001);
      ePtr = 6'h01;
      byteChk(8'hA5);
    end
    host.setPins(3'h5);
    pinV = 3'h5;
    byteChk(8'h3C);
    mode = `MODE_MUX3;
    wr(`REG_CTRL, 32'h00000002);
    wr(`REG_DEVSEL, 32'h00000004);
    eSub = 3'h4;
    wr(`REG_PTR, 32'h00000026);
    ePtr = 6'h26;
    byteChk(8'hFF);
    wr(`REG_PTR, 32'h00000000);
    ePtr = 6'h00;
    byteChk(8'hB6);
    wr(`REG_PTR, 32'h00000002);
    ePtr = 6'h02;
    byteChk(8'h5B);
    wr(`REG_PTR, 32'h0000002D);
    rdChk("ptr big", `REG_PTR, 32'h00000000);
    rdChk("gap", 6'h3F, 32'h00000000);
    rdChk("mode", `REG_CTRL, {30'h00000000, mode});
    rdChk("last", `REG_DATA, 32'h0000005B);
    rdChk("status", `REG_STATUS,
      32'(pinV) | (32'h00000001 << `STATUS_MATCH_BIT));
    wr(`REG_RAMCOL, 32'h00000002);
    rdChk("col", `REG_RAMCOL,
      {18'h00000, 6'h02, 4'h0, expRam[8 +: 4]});
    wr(`REG_DEVSEL, 32'h00000003);
    rdChk("nomatch", `REG_STATUS, 32'(pinV));
    testDone();
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    errors++;
    testDone();
  end
endmodule // lcd_display_ram_write_addressing_tb
